// ===== rtl/ompc_pkg.sv
// Shared constants of the on-chip memory port controller
package ompc_pkg;
    // ------------------------------------------------------------
    // Control bus register indices, relative to the base index
    // ------------------------------------------------------------
    localparam int          IDX_W       = 10;
    localparam logic [9:0]  DS_CTRL     = 10'h000;
    localparam logic [9:0]  DS_RANGE    = 10'h001;
    localparam logic [9:0]  IS_CTRL     = 10'h002;
    localparam logic [9:0]  IS_RANGE    = 10'h003;
    localparam logic [9:0]  IS_INIT     = 10'h004;
    localparam logic [9:0]  IS_FILL     = 10'h005;
    localparam logic [9:0]  BASE_IDX    = 10'h040;
    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int          MULTI_BIT   = 0;
    localparam int          CYC_LSB     = 1;
    localparam int          CYC_W       = 3;
    localparam int          PEND_BIT    = 6;
    localparam int          BUSY_BIT    = 7;
    localparam logic [7:0]  CTRL_WMASK  = 8'h0f;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [7:0]  RANGE_RST   = 8'h00;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;
    // ------------------------------------------------------------
    // Address layout and access timing
    // ------------------------------------------------------------
    localparam int          REGION_LSB  = 24;
    localparam int          D_ADDR_LSB  = 2;
    localparam int          D_ADDR_W    = 22;
    localparam int          I_ADDR_LSB  = 3;
    localparam int          I_ADDR_W    = 21;
    localparam int          CNT_W       = 4;
    localparam logic [3:0]  CYC_SINGLE  = 4'h1;
    localparam logic [3:0]  CYC_MIN     = 4'h2;
    localparam logic [31:0] INIT_STEP   = 32'h0000_0004;
endpackage

// ===== rtl/ompc_access_seq.sv
// Multi-cycle access sequencer shared by both memory ports
`timescale 1ns/1ps
module ompc_access_seq (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic [3:0] cycles,
    output logic            busy,
    output logic            finish
);
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_WAIT = 2'b10
    } ompc_seq_state_t;

    typedef struct packed {
        ompc_seq_state_t                st;
        logic [ompc_pkg::CNT_W-1:0]     cnt;
    } ompc_seq_t;

    ompc_seq_t r;
    ompc_seq_t next_r;

    // ------------------------------------------------------------
    // Count the RAM edges of one access
    // ------------------------------------------------------------
    assign busy   = (r.st == SEQ_WAIT);
    assign finish = busy && (r.cnt == '0);

    // Start is ignored while busy, so the count cannot be restarted
    always_comb begin
        next_r = r;
        case (r.st)
            SEQ_IDLE: begin
                if (start) begin
                    next_r.st  = SEQ_WAIT;
                    next_r.cnt = cycles;
                end
            end
            SEQ_WAIT: begin
                if (r.cnt == '0) begin
                    next_r.st = SEQ_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            default: begin
                next_r.st  = SEQ_IDLE;
                next_r.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '{st: SEQ_IDLE, cnt: '0};
        end else begin
            r <= next_r;
        end
    end
endmodule // ompc_access_seq

// ===== rtl/ompc_fill_seq.sv
// Holds a pending instruction RAM fill until the port is free
`timescale 1ns/1ps
module ompc_fill_seq (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic fill_req,
    input  wire logic port_free,
    output logic      pending,
    output logic      go
);
    typedef enum logic [1:0] {
        FILL_IDLE = 2'b01,
        FILL_PEND = 2'b10
    } ompc_fill_state_t;

    typedef struct packed {
        ompc_fill_state_t st;
    } ompc_fill_t;

    ompc_fill_t r;
    ompc_fill_t next_r;

    // ------------------------------------------------------------
    // Fetches win the port; a fill waits for a free cycle
    // ------------------------------------------------------------
    assign pending = (r.st == FILL_PEND);
    assign go      = pending && port_free;

    // A new fill request while one waits and the port is not free is merged, the data is latest
    always_comb begin
        next_r = r;
        case (r.st)
            FILL_IDLE: begin
                if (fill_req) begin
                    next_r.st = FILL_PEND;
                end
            end
            FILL_PEND: begin
                if (port_free && !fill_req) begin
                    next_r.st = FILL_IDLE;
                end
            end
            default: begin
                next_r.st = FILL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '{st: FILL_IDLE};
        end else begin
            r <= next_r;
        end
    end
endmodule // ompc_fill_seq

// ===== rtl/ompc_top.sv
// On-chip memory port controller: data and instruction RAM ports
//
// Function
// - Each port: one-clock access, or multi-cycle of two to eight clocks.
// - Control bus register addresses set by a design parameter.
// - Each side owns its own 16 MB region of the memory map.
// - Address outputs reach 16 MB data, 16 MB instruction.
// - Data side has separate 32-bit read and write buses.
// - Data side writes single bytes, one enable per lane.
// - Data side drives a 22-bit RAM address.
// - Data side holds 8-bit control and range registers.
// - Data RAM written only by core stores through the data side.
// - Instruction fetch is 64-bit read-only, two instructions per clock.
// - Instruction RAM has a 32-bit write path via control registers.
// - Instruction side drives its own 21-bit RAM address.
// - Instruction side holds 8-bit control and range registers.
// - Instruction side holds 32-bit init and fill registers.
// - Instruction RAM written by configuration or register writes.
// - Control bus decodes 10 address bits, outside the memory map.
`timescale 1ns/1ps
module ompc_top #(
    parameter logic [9:0] BASE = ompc_pkg::BASE_IDX
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    // APB register slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Core data side
    input  wire logic        core_d_req,
    input  wire logic        core_d_we,
    input  wire logic [3:0]  core_d_be,
    input  wire logic [31:0] core_d_addr,
    input  wire logic [31:0] core_d_wdata,
    output logic [31:0]      core_d_rdata,
    output logic             core_d_done,
    // Data RAM port
    output logic             dram_en,
    output logic [3:0]       dram_we,
    output logic [21:0]      dram_addr,
    output logic [31:0]      dram_wdata,
    input  wire logic [31:0] dram_rdata,
    // Core instruction side
    input  wire logic        core_i_req,
    input  wire logic [31:0] core_i_addr,
    output logic [63:0]      core_i_rdata,
    output logic             core_i_done,
    // Instruction RAM port
    output logic             iram_en,
    output logic [1:0]       iram_we,
    output logic [20:0]      iram_addr,
    output logic [31:0]      iram_wdata,
    input  wire logic [63:0] iram_rdata
);
    typedef struct packed {
        logic [7:0]  ds_ctrl;
        logic [7:0]  ds_range;
        logic [7:0]  is_ctrl;
        logic [7:0]  is_range;
        logic [31:0] is_init;
        logic [31:0] is_fill;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        d_en;
        logic [3:0]  d_we;
        logic [21:0] d_addr;
        logic [31:0] d_wdata;
        logic [31:0] d_rdata;
        logic        d_done;
        logic        i_en;
        logic [1:0]  i_we;
        logic [20:0] i_addr;
        logic [31:0] i_wdata;
        logic [63:0] i_rdata;
        logic        i_done;
    } ompc_top_t;

    ompc_top_t r;
    ompc_top_t next_r;

    logic       d_busy;
    logic       d_fin;
    logic       d_start;
    logic       i_busy;
    logic       i_fin;
    logic       i_start;
    logic       fill_req;
    logic       fill_pend;
    logic       fill_go;
    logic [9:0] idx;
    logic       wr_acc;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Access length in RAM clocks from a control register
    function automatic logic [3:0] cycles_of(input logic [7:0] ctrl);
        logic [3:0] cyc;
        cyc = {1'b0, ctrl[ompc_pkg::CYC_LSB +: ompc_pkg::CYC_W]} + 4'h1;
        if (!ctrl[ompc_pkg::MULTI_BIT]) begin
            cycles_of = ompc_pkg::CYC_SINGLE;
        end else if (cyc < ompc_pkg::CYC_MIN) begin
            cycles_of = ompc_pkg::CYC_MIN;
        end else begin
            cycles_of = cyc;
        end
    endfunction

    // Region hit: top address byte against the range register
    function automatic logic hit(input logic [31:0] a,
                                 input logic [7:0]  rng);
        hit = (a[31:ompc_pkg::REGION_LSB] == rng);
    endfunction

    // ------------------------------------------------------------
    // Request acceptance and sequencers
    // ------------------------------------------------------------
    assign idx      = paddr[11:2] - BASE;
    assign wr_acc   = psel && penable && r.pready && pwrite && !r.pslverr;
    assign d_start  = core_d_req && !d_busy && hit(core_d_addr, r.ds_range);
    assign i_start  = core_i_req && !i_busy && hit(core_i_addr, r.is_range);
    assign fill_req = wr_acc && (idx == ompc_pkg::IS_FILL);

    ompc_access_seq u_dseq (
        .clk    (clk),
        .resetn (resetn),
        .start  (d_start),
        .cycles (cycles_of(r.ds_ctrl)),
        .busy   (d_busy),
        .finish (d_fin)
    );

    ompc_access_seq u_iseq (
        .clk    (clk),
        .resetn (resetn),
        .start  (i_start),
        .cycles (cycles_of(r.is_ctrl)),
        .busy   (i_busy),
        .finish (i_fin)
    );

    // Fill only on a cycle with no fetch running or starting
    ompc_fill_seq u_fill (
        .clk       (clk),
        .resetn    (resetn),
        .fill_req  (fill_req),
        .port_free (!i_busy && !i_start),
        .pending   (fill_pend),
        .go        (fill_go)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r        = r;
        next_r.d_done = 1'b0;
        next_r.i_done = 1'b0;
        next_r.i_we   = 2'b00;

        // Answer one cycle after setup, so pready stands in access
        next_r.pready  = psel && !penable;
        next_r.pslverr = psel && !penable && (idx > ompc_pkg::IS_FILL);
        next_r.prdata  = '0;
        case (idx)
            ompc_pkg::DS_CTRL: begin
                next_r.prdata[7:0] = r.ds_ctrl;
                next_r.prdata[ompc_pkg::BUSY_BIT] = d_busy;
            end
            ompc_pkg::DS_RANGE: next_r.prdata[7:0] = r.ds_range;
            ompc_pkg::IS_CTRL: begin
                next_r.prdata[7:0] = r.is_ctrl;
                next_r.prdata[ompc_pkg::PEND_BIT] = fill_pend;
                next_r.prdata[ompc_pkg::BUSY_BIT] = i_busy;
            end
            ompc_pkg::IS_RANGE: next_r.prdata[7:0] = r.is_range;
            ompc_pkg::IS_INIT:  next_r.prdata = r.is_init;
            ompc_pkg::IS_FILL:  next_r.prdata = r.is_fill;
            default:            next_r.prdata = '0;
        endcase

        // Register writes; status bits are read-only
        if (wr_acc) begin
            case (idx)
                ompc_pkg::DS_CTRL: next_r.ds_ctrl = pwdata[7:0] & ompc_pkg::CTRL_WMASK;
                ompc_pkg::DS_RANGE: next_r.ds_range = pwdata[7:0];
                ompc_pkg::IS_CTRL: next_r.is_ctrl = pwdata[7:0] & ompc_pkg::CTRL_WMASK;
                ompc_pkg::IS_RANGE: next_r.is_range = pwdata[7:0];
                ompc_pkg::IS_INIT:  next_r.is_init  = pwdata;
                ompc_pkg::IS_FILL:  next_r.is_fill  = pwdata;
                default: begin
                end
            endcase
        end

        // Data side: drive once, hold to the end, then sample
        if (d_start) begin
            next_r.d_en    = 1'b1;
            next_r.d_we    = core_d_we ? core_d_be : 4'h0;
            next_r.d_addr  = core_d_addr[ompc_pkg::D_ADDR_LSB +: ompc_pkg::D_ADDR_W];
            next_r.d_wdata = core_d_wdata;
        end else if (d_fin) begin
            next_r.d_en    = 1'b0;
            next_r.d_we    = 4'h0;
            next_r.d_rdata = dram_rdata;
            next_r.d_done  = 1'b1;
        end

        // Instruction side fetch, same holding scheme
        if (i_start) begin
            next_r.i_en   = 1'b1;
            next_r.i_addr = core_i_addr[ompc_pkg::I_ADDR_LSB +: ompc_pkg::I_ADDR_W];
        end else if (i_fin) begin
            next_r.i_en    = 1'b0;
            next_r.i_rdata = iram_rdata;
            next_r.i_done  = 1'b1;
        end else if (fill_go) begin
            // One-clock write of the fill word into one half
            next_r.i_en    = 1'b1;
            next_r.i_addr  = r.is_init[ompc_pkg::I_ADDR_LSB +: ompc_pkg::I_ADDR_W];
            next_r.i_wdata = r.is_fill;
            next_r.i_we    = r.is_init[2] ? 2'b10 : 2'b01;
            next_r.is_init = r.is_init + ompc_pkg::INIT_STEP;
        end else if (!i_busy) begin
            next_r.i_en = 1'b0;
        end

        // A software write to the init register beats the increment
        if (wr_acc && idx == ompc_pkg::IS_INIT) begin
            next_r.is_init = pwdata;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r          <= '0;
            r.ds_ctrl  <= ompc_pkg::CTRL_RST;
            r.ds_range <= ompc_pkg::RANGE_RST;
            r.is_ctrl  <= ompc_pkg::CTRL_RST;
            r.is_range <= ompc_pkg::RANGE_RST;
            r.is_init  <= ompc_pkg::WORD_RST;
            r.is_fill  <= ompc_pkg::WORD_RST;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    // Address outputs reach the whole 16 MB region on each side with bits 23:2 (data) and 23:3 (instruction) below the region byte
    assign pready       = r.pready;
    assign prdata       = r.prdata;
    assign pslverr      = r.pslverr;
    assign core_d_rdata = r.d_rdata;
    assign core_d_done  = r.d_done;
    assign dram_en      = r.d_en;
    assign dram_we      = r.d_we;
    assign dram_addr    = r.d_addr;
    assign dram_wdata   = r.d_wdata;
    assign core_i_rdata = r.i_rdata;
    assign core_i_done  = r.i_done;
    assign iram_en      = r.i_en;
    assign iram_we      = r.i_we;
    assign iram_addr    = r.i_addr;
    assign iram_wdata   = r.i_wdata;
endmodule // ompc_top

// ===== testbench/ompc_props.sv
// Port-level checks of the on-chip memory port controller
`timescale 1ns/1ps
module ompc_props (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        core_d_we,
    input wire logic [3:0]  core_d_be,
    input wire logic [31:0] core_d_addr,
    input wire logic        core_d_done,
    input wire logic        dram_en,
    input wire logic [3:0]  dram_we,
    input wire logic [21:0] dram_addr,
    input wire logic [31:0] core_i_addr,
    input wire logic        core_i_done,
    input wire logic        iram_en,
    input wire logic [1:0]  iram_we,
    input wire logic [20:0] iram_addr
);
    // ------------------------------------------------------------
    // Word addresses the RAM ports must carry
    // ------------------------------------------------------------
    logic [21:0] d_word;
    logic [20:0] i_word;
    assign d_word = core_d_addr[23:2];
    assign i_word = core_i_addr[23:3];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    a_apb_answer: assert property ((psel && !penable) |=> pready)
        else $error("no answer after setup");
    a_pready_once: assert property (pready |=> !pready)
        else $error("answer held too long");
    a_err_zero: assert property (pslverr |-> (pready && prdata == 32'h0))
        else $error("error answer carries data");

    // ------------------------------------------------------------
    // Data port: mapping, hold and length of an access
    // ------------------------------------------------------------
    a_d_map: assert property ($rose(dram_en) |-> (dram_addr == $past(d_word) &&
        dram_we == ($past(core_d_we) ? $past(core_d_be) : 4'h0)))
        else $error("data port address or lanes wrong");
    a_d_hold: assert property ((dram_en && $past(dram_en)) |->
        ($stable(dram_addr) && $stable(dram_we)))
        else $error("data port moved mid access");
    a_d_length: assert property ($rose(dram_en) |=> dram_en ##[1:8] !dram_en)
        else $error("data access length out of range");
    a_d_done_end: assert property (core_d_done == $fell(dram_en))
        else $error("data done not at access end");

    // ------------------------------------------------------------
    // Instruction port
    // ------------------------------------------------------------
    a_i_map: assert property (($rose(iram_en) && iram_we == 2'h0) |->
        iram_addr == $past(i_word))
        else $error("fetch address wrong");
    a_i_done_en: assert property (core_i_done |-> $past(iram_en))
        else $error("fetch done without access");
    a_fill_pulse: assert property ((iram_we != 2'h0) |-> $onehot(iram_we) ##1
        (iram_we == 2'h0))
        else $error("fill write not a single half pulse");
endmodule // ompc_props

// ===== testbench/ompc_ram_model.sv
// Synchronous RAM pair standing in for the fabric memories
`timescale 1ns/1ps
module ompc_ram_model (
    input  wire logic        clk,
    input  wire logic        dram_en,
    input  wire logic [3:0]  dram_we,
    input  wire logic [21:0] dram_addr,
    input  wire logic [31:0] dram_wdata,
    output logic      [31:0] dram_rdata = 32'h0,
    input  wire logic        iram_en,
    input  wire logic [1:0]  iram_we,
    input  wire logic [20:0] iram_addr,
    input  wire logic [31:0] iram_wdata,
    output logic      [63:0] iram_rdata = 64'h0
);
    logic [31:0] dmem [0:63];
    logic [63:0] imem [0:31];

    // Data RAM, byte lanes; an idle port toggles so stale data never looks valid
    always @(posedge clk) begin
        if (dram_en) begin
            for (int b = 0; b < 4; b++) begin
                if (dram_we[b]) dmem[dram_addr[5:0]][8*b +: 8] <= dram_wdata[8*b +: 8];
            end
            dram_rdata <= dmem[dram_addr[5:0]];
        end else begin
            dram_rdata <= ~dram_rdata;
        end
    end

    // Instruction RAM: fetch side only reads, fills arrive a half at a time
    always @(posedge clk) begin
        if (iram_we[0]) imem[iram_addr[4:0]][31:0] <= iram_wdata;
        if (iram_we[1]) imem[iram_addr[4:0]][63:32] <= iram_wdata;
        if (iram_en) iram_rdata <= imem[iram_addr[4:0]];
        else iram_rdata <= ~iram_rdata;
    end
endmodule // ompc_ram_model

// ===== testbench/tb_ompc_top.sv
// Self-checking bench of the on-chip memory port controller
`timescale 1ns/1ps
`define check_eq(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_ompc_top;
    localparam logic [9:0] BASE = 10'h100;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, core_d_rdata, dram_wdata, iram_wdata, dram_rdata;
    logic        core_d_req = 1'b0, core_d_we = 1'b0, core_d_done, dram_en, iram_en;
    logic [3:0]  core_d_be = 4'h0, dram_we;
    logic [31:0] core_d_addr = 32'h0, core_d_wdata = 32'h0, core_i_addr = 32'h0;
    logic        core_i_req = 1'b0, core_i_done;
    logic [63:0] core_i_rdata, iram_rdata;
    logic [21:0] dram_addr;
    logic [20:0] iram_addr;
    logic [1:0]  iram_we;
    int          fail_count = 0;
    int          check_count = 0;

    ompc_top #(.BASE(BASE)) uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .core_d_req(core_d_req), .core_d_we(core_d_we), .core_d_be(core_d_be),
        .core_d_addr(core_d_addr), .core_d_wdata(core_d_wdata), .core_d_rdata(core_d_rdata),
        .core_d_done(core_d_done), .dram_en(dram_en), .dram_we(dram_we), .dram_addr(dram_addr),
        .dram_wdata(dram_wdata), .dram_rdata(dram_rdata), .core_i_req(core_i_req),
        .core_i_addr(core_i_addr), .core_i_rdata(core_i_rdata), .core_i_done(core_i_done),
        .iram_en(iram_en), .iram_we(iram_we), .iram_addr(iram_addr), .iram_wdata(iram_wdata),
        .iram_rdata(iram_rdata));

    ompc_ram_model ram (.clk(clk), .dram_en(dram_en), .dram_we(dram_we), .dram_addr(dram_addr),
        .dram_wdata(dram_wdata), .dram_rdata(dram_rdata), .iram_en(iram_en),
        .iram_we(iram_we), .iram_addr(iram_addr), .iram_wdata(iram_wdata),
        .iram_rdata(iram_rdata));

    // ------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic close_out();
        if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // A hang anywhere ends the run as a failure
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    // APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx + BASE, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            close_out();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // One core access; lat counts edges from the taking edge, 0 if never done
    task automatic core(input logic side, input logic we, input logic [3:0] be,
                        input logic [31:0] addr, input logic [31:0] wd,
                        output logic [63:0] rd, output int lat);
        @(posedge clk);
        core_i_req <= side;
        core_i_addr <= addr;
        core_d_req <= !side;
        core_d_we <= we;
        core_d_be <= be;
        core_d_addr <= addr;
        core_d_wdata <= wd;
        @(posedge clk);
        core_i_req <= 1'b0;
        core_d_req <= 1'b0;
        lat = 0;
        rd = 64'h0;
        for (int n = 1; n <= 14; n++) begin
            @(posedge clk);
            if ((side ? core_i_done : core_d_done) === 1'b1) begin
                lat = n;
                rd = side ? core_i_rdata : {32'h0, core_d_rdata};
                break;
            end
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r, w, a;
        logic        e;
        logic [63:0] q;
        int          lat;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        // Reset values, then an index past the last register
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, i[9:0], 32'h0, r, e);
            `check_eq({e, r}, 33'h0)
        end
        apb(1'b0, 10'h006, 32'h0, r, e);
        `check_eq({e, r}, {1'b1, 32'h0})
        // Region registers keep eight bits, the control register its four writable bits
        apb(1'b1, ompc_pkg::DS_RANGE, 32'habcd_ef11, r, e);
        apb(1'b1, ompc_pkg::IS_RANGE, 32'h1234_5622, r, e);
        apb(1'b0, ompc_pkg::DS_RANGE, 32'h0, r, e);
        `check_eq(r, 32'h0000_0011)
        apb(1'b0, ompc_pkg::IS_RANGE, 32'h0, r, e);
        `check_eq(r, 32'h0000_0022)
        apb(1'b1, ompc_pkg::DS_CTRL, 32'h0000_00ff, r, e);
        apb(1'b0, ompc_pkg::DS_CTRL, 32'h0, r, e);
        `check_eq(r, 32'h0000_000f)
        // Every access length: word write, byte merge, read back
        for (int m = 1; m <= 8; m++) begin
            w = {4{m[7:0]}} ^ 32'h5a5a_a5a5;
            a = {8'h11, m[7:0] ^ 8'hc3, 8'h00, m[5:0], 2'b00};
            apb(1'b1, ompc_pkg::DS_CTRL, (m == 1) ? 32'h0 : {28'h0, 3'(m - 1), 1'b1}, r, e);
            core(1'b0, 1'b1, 4'hf, a, w, q, lat);
            `check_eq(lat, m + 2)
            core(1'b0, 1'b1, 4'b0100, a, 32'hffff_ffff, q, lat);
            core(1'b0, 1'b0, 4'h0, a, 32'h0, q, lat);
            `check_eq(q[31:0], {w[31:24], 8'hff, w[15:0]})
            `check_eq(lat, m + 2)
        end
        core(1'b0, 1'b0, 4'h0, 32'h2200_0004, 32'h0, q, lat);
        `check_eq(lat, 0)
        // Two fills into one doubleword, then fetch it whole
        apb(1'b1, ompc_pkg::IS_INIT, 32'h0000_0010, r, e);
        apb(1'b1, ompc_pkg::IS_FILL, 32'hcafe_0001, r, e);
        apb(1'b1, ompc_pkg::IS_FILL, 32'hbeef_0002, r, e);
        apb(1'b0, ompc_pkg::IS_INIT, 32'h0, r, e);
        `check_eq(r, 32'h0000_0018)
        apb(1'b0, ompc_pkg::IS_CTRL, 32'h0, r, e);
        `check_eq(r, 32'h0)
        core(1'b1, 1'b0, 4'h0, 32'h2200_0010, 32'h0, q, lat);
        `check_eq(q, 64'hbeef_0002_cafe_0001)
        `check_eq(lat, 3)
        apb(1'b1, ompc_pkg::IS_CTRL, 32'h0000_000f, r, e);
        core(1'b1, 1'b0, 4'h0, 32'h2200_0010, 32'h0, q, lat);
        `check_eq(lat, 10)
        core(1'b1, 1'b0, 4'h0, 32'h1100_0010, 32'h0, q, lat);
        `check_eq(lat, 0)
        // Reset in mid-run clears the registers again
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, ompc_pkg::DS_RANGE, 32'h0, r, e);
        `check_eq(r, 32'h0)
        close_out();
    end
endmodule // tb_ompc_top

bind ompc_top ompc_props chk (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .core_d_we(core_d_we),
    .core_d_be(core_d_be), .core_d_addr(core_d_addr), .core_d_done(core_d_done),
    .dram_en(dram_en), .dram_we(dram_we), .dram_addr(dram_addr), .core_i_addr(core_i_addr),
    .core_i_done(core_i_done), .iram_en(iram_en), .iram_we(iram_we), .iram_addr(iram_addr));
